// ---- status_led_defs.svh ----
`ifndef STATUS_LED_DEFS_SVH
`define STATUS_LED_DEFS_SVH

// ==========================================================================
// Register offsets.
`define REG_CONFIG       8'h00
`define REG_POWER_ON     8'h04
`define REG_MODULE       8'h08
`define REG_NETWORK      8'h0C
`define REG_DRIVE        8'h10
`define REG_SYSTEM       8'h14
`define REG_BLINK        8'h18
`define REG_INPUT_LAMP   8'h1C
`define REG_INPUT_TYPE   8'h20
`define REG_EXTRA        8'h24
`define REG_STATE        8'h28

// ==========================================================================
// Field positions.
`define CFG_SWAP_BIT     0
`define CFG_DOWNLOAD_BIT 1
`define DRV_OPEN_BIT     8
`define DRV_SHORT_BIT    9
`define SYS_UNRECOV_BIT  0
`define SYS_ENABLE_BIT   1
`define SYS_READY_BIT    2
`define SYS_LOW_SUP_BIT  3
`define SYS_OUT1_BIT     4
`define SYS_OUT2_BIT     5
`define SYS_HS_BIT       6
`define EXTRA_HS_LSB     4

// ==========================================================================
// Reset values.
`define POWER_ON_DEFAULT_S 8'h1E

// ==========================================================================
// Timing.
`define CLOCK_PERIOD_NS  10
`define TICK_PERIOD_NS   1000000
`define MS_PER_S         11'h3E8
`define NET_WINDOW_MS    11'h7D0
`define HALF_S_MS        11'h1F4
`define DBL_ON_MS        11'h0C8
`define DBL_SECOND_MS    11'h190
`define SHADE_STEPS      7'h64

`endif

// ---- status_led_pkg.sv ----
package status_led_pkg;

   typedef enum logic [1:0] {
      COLOUR_OFF    = 2'b00,
      COLOUR_GREEN  = 2'b01,
      COLOUR_RED    = 2'b10,
      COLOUR_YELLOW = 2'b11
   } colour_t;

   typedef enum logic [0:0] {
      MODE_POWER_ON = 1'b0,
      MODE_NORMAL   = 1'b1
   } mode_t;

   typedef enum logic [2:0] {
      MOD_NORMAL        = 3'b000,
      MOD_STANDBY       = 3'b001,
      MOD_UNRECOVERABLE = 3'b010,
      MOD_RECOVERABLE   = 3'b011,
      MOD_WRONG_TYPE    = 3'b100
   } modstat_t;

   typedef enum logic [2:0] {
      NET_NONE      = 3'b000,
      NET_UP        = 3'b001,
      NET_PENDING   = 3'b010,
      NET_FAULT     = 3'b011,
      NET_TIMED_OUT = 3'b100
   } netstat_t;

endpackage

// ---- led_timebase.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "status_led_defs.svh"

module led_timebase #(
   parameter int unsigned CYCLES_PER_MS = 100000
) (
   input  wire logic        i_clock,
   input  wire logic        i_nrst,
   output logic      [10:0] o_ms,
   output logic             o_sec_tick,
   output logic      [6:0]  o_ramp
);

   typedef struct packed {
      logic [16:0] cyc;
      logic [10:0] ms;
      logic [6:0]  ramp;
   } tb_state_t;

   tb_state_t q;
   tb_state_t d;
   logic      ms_tick;

   // One free-running count feeds every flash, so all indicators share phase.
   always_comb begin
      d = q;
      ms_tick = (q.cyc == 17'(CYCLES_PER_MS - 1)); // RULE20
      d.cyc = ms_tick ? 17'h00000 : q.cyc + 17'h00001;
      if (ms_tick) begin
         d.ms = (q.ms == `NET_WINDOW_MS - 11'h001) ? 11'h000 : q.ms + 11'h001;
      end
      d.ramp = (q.ramp == `SHADE_STEPS - 7'h01) ? 7'h00 : q.ramp + 7'h01;
   end

   always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign o_ms       = q.ms;
   assign o_ramp     = q.ramp;
   assign o_sec_tick = ms_tick && ((q.ms == `MS_PER_S - 11'h001) ||
                                   (q.ms == `NET_WINDOW_MS - 11'h001));

endmodule
`default_nettype wire

// ---- led_shade.sv ----
`timescale 1ns/1ns
`default_nettype none

module led_shade (
   input  wire logic [6:0]              i_percent,
   input  wire logic [6:0]              i_ramp,
   output var status_led_pkg::colour_t  o_colour
);

   // Green share grows with the percentage; values above full scale saturate.
   assign o_colour = (i_percent == 7'h00)  ? status_led_pkg::COLOUR_OFF :
                     (i_ramp < i_percent)  ? status_led_pkg::COLOUR_GREEN :
                                             status_led_pkg::COLOUR_RED;

endmodule
`default_nettype wire

// ---- status_led_sequencer.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "status_led_defs.svh"

// Function
// RULE1: Download alternates green on indicators one, three.
// RULE2: Power-on period first, default thirty seconds.
// RULE3: Software may change the power-on length.
// RULE4: Power-on: three, four module; one, two network.
// RULE5: Module status green, flash green, red, flash red.
// RULE6: Wrong module type alternates red/green, not operational.
// RULE7: Network off, green when up, red on fault.
// RULE8: Pending network flashes green twice per two seconds.
// RULE9: Timed-out network flashes red twice per two seconds.
// RULE10: Normal mode holds until the next reset.
// RULE11: Normal mode meanings for the four indicators.
// RULE12: Configuration bit swaps the two indicator sides.
// RULE13: Written blink count blinks that many, then stops.
// RULE14: Toggle-type input lamp holds its written state.
// RULE15: Extra indicators follow their control bits.
// RULE16: High-side outputs drive while control bit true.
// RULE17: Drive indicator shades red to green, flashes faults.
// RULE18: Indicator three red, yellow latched, green, flash red.
// RULE19: Indicator four shows output faults and blink codes.
// RULE20: One free-running tick times every flash.
module status_led_sequencer #(
   parameter int unsigned CYCLES_PER_MS = `TICK_PERIOD_NS / `CLOCK_PERIOD_NS
) (
   input  wire logic        i_clock,
   input  wire logic        i_nrst,
   input  wire logic [7:0]  i_address,
   input  wire logic [31:0] i_wdata,
   input  wire logic        i_write,
   input  wire logic        i_read,
   output logic      [31:0] o_rdata,
   input  wire logic [7:0]  i_digital_input,
   output logic      [3:0]  o_indicator_red,
   output logic      [3:0]  o_indicator_green,
   output logic             o_status_lamp,
   output logic      [7:0]  o_input_lamp,
   output logic      [3:0]  o_extra_indicator,
   output logic      [3:0]  o_high_side_output,
   output logic             o_module_operational
);

   // =======================================================================
   // State.
   typedef struct packed {
      status_led_pkg::mode_t    mode;
      logic [7:0]               sec;
      logic [7:0]               power_on_len;
      logic                     swap;
      logic                     download;
      status_led_pkg::modstat_t modstat;
      status_led_pkg::netstat_t netstat;
      logic [6:0]               percent;
      logic                     open;
      logic                     short_c;
      logic [6:0]               sys;
      logic [7:0]               blink_cnt;
      logic                     blink_run;
      logic [7:0]               lamp_val;
      logic [7:0]               lamp_type;
      logic [7:0]               din_s1;
      logic [7:0]               din_s2;
      logic [7:0]               lamp_out;
      logic [3:0]               extra;
      logic [3:0]               hs;
      logic [3:0]               red;
      logic [3:0]               green;
      logic                     status_lamp;
      logic                     operational;
      logic [31:0]              rdata;
   } state_t;

   state_t                      q;
   state_t                      d;
   logic [10:0]                 ms;
   logic                        sec_tick;
   logic [6:0]                  ramp;
   status_led_pkg::colour_t     shade;
   logic                        half;
   logic                        dbl;
   status_led_pkg::colour_t     net_c;
   status_led_pkg::colour_t     mod_c;
   status_led_pkg::colour_t     drv_c;
   status_led_pkg::colour_t     sys_c;
   status_led_pkg::colour_t     err_c;
   status_led_pkg::colour_t     log_c [4];
   status_led_pkg::colour_t     phy_c [4];

   // =======================================================================
   // Helpers.
   function automatic status_led_pkg::colour_t gate(status_led_pkg::colour_t c, logic on);
      return on ? c : status_led_pkg::COLOUR_OFF;
   endfunction

   // On for the first half of every second.
   function automatic logic half_on(logic [10:0] t);
      return (t < `HALF_S_MS) || ((t >= `MS_PER_S) && (t < `MS_PER_S + `HALF_S_MS));
   endfunction

   // Two short flashes at the start of every two-second window.
   function automatic logic double_on(logic [10:0] t);
      return (t < `DBL_ON_MS) || ((t >= `DBL_SECOND_MS) && (t < `DBL_SECOND_MS + `DBL_ON_MS));
   endfunction

   led_timebase #(
      .CYCLES_PER_MS (CYCLES_PER_MS)
   ) u_timebase (
      .i_clock    (i_clock),
      .i_nrst     (i_nrst),
      .o_ms       (ms),
      .o_sec_tick (sec_tick),
      .o_ramp     (ramp)
   );

   led_shade u_shade (
      .i_percent (q.percent),
      .i_ramp    (ramp),
      .o_colour  (shade)
   );

   // =======================================================================
   // Indicator meanings.
   always_comb begin
      half = half_on(ms); // RULE20
      dbl  = double_on(ms);
      unique case (q.netstat)
         status_led_pkg::NET_NONE:      net_c = status_led_pkg::COLOUR_OFF; // RULE7
         status_led_pkg::NET_UP:        net_c = status_led_pkg::COLOUR_GREEN; // RULE7
         status_led_pkg::NET_PENDING:   net_c = gate(status_led_pkg::COLOUR_GREEN, dbl); // RULE8
         status_led_pkg::NET_FAULT:     net_c = status_led_pkg::COLOUR_RED; // RULE7
         status_led_pkg::NET_TIMED_OUT: net_c = gate(status_led_pkg::COLOUR_RED, dbl); // RULE9
         default:                       net_c = status_led_pkg::COLOUR_OFF;
      endcase
      unique case (q.modstat)
         status_led_pkg::MOD_NORMAL:        mod_c = status_led_pkg::COLOUR_GREEN; // RULE5
         status_led_pkg::MOD_STANDBY:       mod_c = gate(status_led_pkg::COLOUR_GREEN, half); // RULE5
         status_led_pkg::MOD_UNRECOVERABLE: mod_c = status_led_pkg::COLOUR_RED; // RULE5
         status_led_pkg::MOD_RECOVERABLE:   mod_c = gate(status_led_pkg::COLOUR_RED, half); // RULE5
         status_led_pkg::MOD_WRONG_TYPE:
            mod_c = half ? status_led_pkg::COLOUR_RED : status_led_pkg::COLOUR_GREEN; // RULE6
         default:                           mod_c = status_led_pkg::COLOUR_OFF;
      endcase
      // A short outranks an open, and either outranks the level shading.
      if (q.short_c) begin
         drv_c = gate(status_led_pkg::COLOUR_RED, half); // RULE17
      end else if (q.open) begin
         drv_c = gate(status_led_pkg::COLOUR_GREEN, half); // RULE17
      end else begin
         drv_c = shade; // RULE17
      end
      if (q.sys[`SYS_UNRECOV_BIT]) begin
         sys_c = status_led_pkg::COLOUR_RED; // RULE18
      end else if (q.sys[`SYS_LOW_SUP_BIT]) begin
         sys_c = gate(status_led_pkg::COLOUR_RED, half); // RULE18
      end else if (q.sys[`SYS_ENABLE_BIT]) begin
         sys_c = status_led_pkg::COLOUR_YELLOW; // RULE18
      end else if (q.sys[`SYS_READY_BIT]) begin
         sys_c = status_led_pkg::COLOUR_GREEN; // RULE18
      end else begin
         sys_c = status_led_pkg::COLOUR_OFF;
      end
      if (q.sys[`SYS_OUT1_BIT]) begin
         err_c = status_led_pkg::COLOUR_RED; // RULE19
      end else if (q.sys[`SYS_OUT2_BIT]) begin
         err_c = status_led_pkg::COLOUR_GREEN; // RULE19
      end else if (q.sys[`SYS_HS_BIT]) begin
         err_c = gate(status_led_pkg::COLOUR_YELLOW, half); // RULE19
      end else begin
         err_c = gate(status_led_pkg::COLOUR_RED, q.blink_run && half); // RULE19
      end
      if (q.download) begin
         log_c[0] = gate(status_led_pkg::COLOUR_GREEN, half); // RULE1
         log_c[1] = status_led_pkg::COLOUR_OFF;
         log_c[2] = gate(status_led_pkg::COLOUR_GREEN, !half); // RULE1
         log_c[3] = status_led_pkg::COLOUR_OFF;
      end else if (q.mode == status_led_pkg::MODE_POWER_ON) begin
         log_c[0] = net_c; // RULE4
         log_c[1] = net_c; // RULE4
         log_c[2] = mod_c; // RULE4
         log_c[3] = mod_c; // RULE4
      end else begin
         log_c[0] = net_c; // RULE11
         log_c[1] = drv_c; // RULE11
         log_c[2] = sys_c; // RULE11
         log_c[3] = err_c; // RULE11
      end
      // Swapping exchanges the two sides: one with three, two with four.
      for (int i = 0; i < 4; i++) begin
         phy_c[i] = q.swap ? log_c[(i + 2) % 4] : log_c[i]; // RULE12
      end
   end

   // =======================================================================
   // Sequencing and registers.
   always_comb begin
      d = q;
      d.rdata = 32'h00000000;
      d.din_s1 = i_digital_input;
      d.din_s2 = q.din_s1;
      if (q.mode == status_led_pkg::MODE_POWER_ON) begin
         if (q.sec >= q.power_on_len) begin
            d.mode = status_led_pkg::MODE_NORMAL; // RULE2 RULE10
         end else if (sec_tick) begin
            d.sec = q.sec + 8'h01; // RULE2
         end
      end
      // The first second boundary starts the run; later ones count blinks.
      if (sec_tick && (q.blink_cnt != 8'h00)) begin
         if (!q.blink_run) begin
            d.blink_run = 1'b1; // RULE13
         end else begin
            d.blink_cnt = q.blink_cnt - 8'h01; // RULE13
            d.blink_run = (q.blink_cnt != 8'h01); // RULE13
         end
      end
      if (i_write) begin
         case (i_address)
            `REG_CONFIG: begin
               d.swap     = i_wdata[`CFG_SWAP_BIT];
               d.download = i_wdata[`CFG_DOWNLOAD_BIT];
            end
            `REG_POWER_ON: d.power_on_len = i_wdata[7:0]; // RULE3
            `REG_MODULE:   d.modstat = status_led_pkg::modstat_t'(i_wdata[2:0]);
            `REG_NETWORK:  d.netstat = status_led_pkg::netstat_t'(i_wdata[2:0]);
            `REG_DRIVE: begin
               d.percent = i_wdata[6:0];
               d.open    = i_wdata[`DRV_OPEN_BIT];
               d.short_c = i_wdata[`DRV_SHORT_BIT];
            end
            `REG_SYSTEM: begin
               d.sys = i_wdata[6:0];
               d.sys[`SYS_ENABLE_BIT] = i_wdata[`SYS_ENABLE_BIT] | q.sys[`SYS_ENABLE_BIT]; // RULE18
            end
            `REG_BLINK: begin
               d.blink_cnt = i_wdata[7:0]; // RULE13
               d.blink_run = 1'b0;
            end
            `REG_INPUT_LAMP: d.lamp_val = i_wdata[7:0]; // RULE14
            `REG_INPUT_TYPE: d.lamp_type = i_wdata[7:0];
            `REG_EXTRA: begin
               d.extra = i_wdata[3:0]; // RULE15
               d.hs    = i_wdata[`EXTRA_HS_LSB +: 4]; // RULE16
            end
            default: ;
         endcase
      end
      if (i_read) begin
         case (i_address)
            `REG_CONFIG:     d.rdata = {30'h00000000, q.download, q.swap};
            `REG_POWER_ON:   d.rdata = {24'h000000, q.power_on_len};
            `REG_MODULE:     d.rdata = {29'h00000000, q.modstat};
            `REG_NETWORK:    d.rdata = {29'h00000000, q.netstat};
            `REG_DRIVE:      d.rdata = {22'h000000, q.short_c, q.open, 1'b0, q.percent};
            `REG_SYSTEM:     d.rdata = {25'h0000000, q.sys};
            `REG_BLINK:      d.rdata = {24'h000000, q.blink_cnt};
            `REG_INPUT_LAMP: d.rdata = {24'h000000, q.lamp_val};
            `REG_INPUT_TYPE: d.rdata = {24'h000000, q.lamp_type};
            `REG_EXTRA:      d.rdata = {24'h000000, q.hs, q.extra};
            `REG_STATE:      d.rdata = {15'h0000, q.sec, 7'h00, q.blink_run, q.mode};
            default:         d.rdata = 32'h00000000;
         endcase
      end
      // Inputs that are not toggle type keep showing their live level.
      d.lamp_out = (q.lamp_type & q.lamp_val) | (~q.lamp_type & q.din_s2); // RULE14
      for (int i = 0; i < 4; i++) begin
         d.red[i]   = phy_c[i][1];
         d.green[i] = phy_c[i][0];
      end
      d.status_lamp = q.blink_run && half; // RULE13
      d.operational = (q.modstat != status_led_pkg::MOD_WRONG_TYPE); // RULE6
   end

   always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         q              <= '0;
         q.power_on_len <= `POWER_ON_DEFAULT_S;
      end else begin
         q <= d;
      end
   end

   assign o_rdata              = q.rdata;
   assign o_indicator_red      = q.red;
   assign o_indicator_green    = q.green;
   assign o_status_lamp        = q.status_lamp;
   assign o_input_lamp         = q.lamp_out;
   assign o_extra_indicator    = q.extra;
   assign o_high_side_output   = q.hs;
   assign o_module_operational = q.operational;

   // =======================================================================
   // Assertions.
   default clocking cb @(posedge i_clock);
   endclocking
   default disable iff (!i_nrst);

   logic plain_view;
   assign plain_view = !q.swap && !q.download && (q.mode == status_led_pkg::MODE_NORMAL);

   sequence s_ext_write;
      i_write && (i_address == `REG_EXTRA);
   endsequence

   property p_download_alt;
      q.download |=> (o_indicator_green[0] != o_indicator_green[2]) && (o_indicator_red == 4'h0);
   endproperty
   a_download_alt: assert property (p_download_alt) else $error("download pattern wrong"); // RULE1

   property p_power_on_end;
      $rose(q.mode) |-> $past(q.sec) >= $past(q.power_on_len);
   endproperty
   a_power_on_end: assert property (p_power_on_end) else $error("power-on ended early"); // RULE2

   property p_normal_holds;
      (q.mode == status_led_pkg::MODE_NORMAL) |=> (q.mode == status_led_pkg::MODE_NORMAL);
   endproperty
   a_normal_holds: assert property (p_normal_holds) else $error("left normal mode"); // RULE10

   property p_wrong_type;
      (q.modstat == status_led_pkg::MOD_WRONG_TYPE) |=> !o_module_operational;
   endproperty
   a_wrong_type: assert property (p_wrong_type) else $error("wrong type still operational"); // RULE6

   property p_net_pending;
      (plain_view && q.netstat == status_led_pkg::NET_PENDING) |=> !o_indicator_red[0];
   endproperty
   a_net_pending: assert property (p_net_pending) else $error("pending network shows red"); // RULE8

   property p_blink_stops;
      (q.blink_cnt == 8'h00 && !(i_write && i_address == `REG_BLINK)) |=> !o_status_lamp [*2];
   endproperty
   a_blink_stops: assert property (p_blink_stops) else $error("blink after count ended"); // RULE13

   property p_extra;
      s_ext_write |=> (o_extra_indicator == $past(i_wdata[3:0]));
   endproperty
   a_extra: assert property (p_extra) else $error("extra indicator mismatch"); // RULE15

   property p_high_side;
      // A back-to-back write to the same register may legally change the drive again.
      s_ext_write |=> (o_high_side_output == $past(i_wdata[7:4])) ##1
         ($stable(o_high_side_output) || $past(i_write && (i_address == `REG_EXTRA)));
   endproperty
   a_high_side: assert property (p_high_side) else $error("high-side output mismatch"); // RULE16

   property p_enable_latch;
      q.sys[`SYS_ENABLE_BIT] |=> q.sys[`SYS_ENABLE_BIT];
   endproperty
   a_enable_latch: assert property (p_enable_latch) else $error("system enable latch lost"); // RULE18

   property p_out1_fault;
      (plain_view && q.sys[`SYS_OUT1_BIT]) |=> o_indicator_red[3] && !o_indicator_green[3];
   endproperty
   a_out1_fault: assert property (p_out1_fault) else $error("output one fault not red"); // RULE19

endmodule
`default_nettype wire

// ---- led_viewer.sv ----
`timescale 1ns/1ns
`default_nettype none

// ==========================================================================
// Operator's eye: counts lit cycles per colour so flash patterns can be
// judged by duty, which does not depend on where a window starts.
module led_viewer (
   input  wire logic        i_clock,
   input  wire logic        i_nrst,
   input  wire logic [3:0]  i_red,
   input  wire logic [3:0]  i_green,
   input  wire logic        i_lamp,
   output logic      [31:0] o_green_on [4],
   output logic      [31:0] o_red_on [4],
   output logic      [31:0] o_both_green,
   output logic      [31:0] o_lamp_flashes
);
   logic lamp_q;

   always_ff @(posedge i_clock or negedge i_nrst) begin
      if (!i_nrst) begin
         for (int k = 0; k < 4; k++) begin
            o_green_on[k] <= 32'h0;
            o_red_on[k]   <= 32'h0;
         end
         o_both_green   <= 32'h0;
         o_lamp_flashes <= 32'h0;
         lamp_q         <= 1'b0;
      end else begin
         for (int k = 0; k < 4; k++) begin
            o_green_on[k] <= o_green_on[k] + {31'h0, i_green[k]};
            o_red_on[k]   <= o_red_on[k] + {31'h0, i_red[k]};
         end
         o_both_green   <= o_both_green + {31'h0, i_green[0] & i_green[2]};
         o_lamp_flashes <= o_lamp_flashes + {31'h0, i_lamp & ~lamp_q};
         lamp_q         <= i_lamp;
      end
   end
endmodule

`default_nettype wire

// ---- test_status_led_sequencer.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "status_led_defs.svh"

module test_status_led_sequencer;
   logic        i_clock = 1'b0;
   logic        i_nrst = 1'b0;
   logic [7:0]  i_address = 8'h00;
   logic [31:0] i_wdata = 32'h0;
   logic        i_write = 1'b0;
   logic        i_read = 1'b0;
   logic [7:0]  i_digital_input = 8'h00;
   logic [31:0] o_rdata;
   logic [3:0]  o_indicator_red, o_indicator_green, o_extra_indicator, o_high_side_output;
   logic [7:0]  o_input_lamp;
   logic        o_status_lamp, o_module_operational;
   logic [31:0] g_on [4], r_on [4], g0 [4], r0 [4], dg [4], dr [4];
   logic [31:0] both, lamps, both0, lamps0, v;
   logic [31:0] mod_g [5] = '{32'h7D0, 32'h3E8, 32'h0, 32'h0, 32'h3E8};
   logic [31:0] mod_r [5] = '{32'h0, 32'h0, 32'h7D0, 32'h3E8, 32'h3E8};
   logic [31:0] net_g [5] = '{32'h0, 32'h7D0, 32'h190, 32'h0, 32'h0};
   logic [31:0] net_r [5] = '{32'h0, 32'h0, 32'h0, 32'h7D0, 32'h190};
   int          num_errors = 0;
   int          check_count = 0;

   always #5 i_clock = ~i_clock;

   // One millisecond per clock keeps a two-second flash window at 2000 cycles.
   status_led_sequencer #(.CYCLES_PER_MS(1)) dut_u (
      .i_clock(i_clock), .i_nrst(i_nrst), .i_address(i_address), .i_wdata(i_wdata),
      .i_write(i_write), .i_read(i_read), .o_rdata(o_rdata), .i_digital_input(i_digital_input),
      .o_indicator_red(o_indicator_red), .o_indicator_green(o_indicator_green),
      .o_status_lamp(o_status_lamp), .o_input_lamp(o_input_lamp),
      .o_extra_indicator(o_extra_indicator), .o_high_side_output(o_high_side_output),
      .o_module_operational(o_module_operational));

   led_viewer view_u (
      .i_clock(i_clock), .i_nrst(i_nrst), .i_red(o_indicator_red), .i_green(o_indicator_green),
      .i_lamp(o_status_lamp), .o_green_on(g_on), .o_red_on(r_on), .o_both_green(both),
      .o_lamp_flashes(lamps));

   // ==========================================================================
   // Bus access and checking.
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic tally_and_finish();
      $display("checks %0d errors %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge i_clock);
      i_address <= a;
      i_wdata   <= d;
      i_write   <= 1'b1;
      @(posedge i_clock);
      i_write   <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge i_clock);
      i_address <= a;
      i_read    <= 1'b1;
      @(posedge i_clock);
      i_read    <= 1'b0;
      #1;
      d = o_rdata;
   endtask

   task automatic snap();
      @(posedge i_clock);
      #1;
      g0 = g_on;
      r0 = r_on;
      both0 = both;
      lamps0 = lamps;
   endtask

   task automatic diff(input int n);
      repeat (n) @(posedge i_clock);
      #1;
      for (int k = 0; k < 4; k++) begin
         dg[k] = g_on[k] - g0[k];
         dr[k] = r_on[k] - r0[k];
      end
   endtask

   task automatic step(input logic [7:0] a, input logic [31:0] d);
      wr(a, d);
      repeat (4) @(posedge i_clock);
      snap();
      diff(2000);
   endtask

   task automatic ex(input int k, input logic [31:0] g, input logic [31:0] r);
      check(dg[k], g);
      check(dr[k], r);
   endtask

   initial begin
      #(1000000);
      num_errors++;
      tally_and_finish();
   end

   // ==========================================================================
   // Main sequence: power-on patterns first, while the period is stretched.
   initial begin
      repeat (16) @(posedge i_clock);
      i_nrst <= 1'b1;
      rd(`REG_POWER_ON, v);
      check(v, 32'h1E);
      wr(`REG_POWER_ON, 32'h28);
      for (int m = 0; m < 5; m++) begin
         step(`REG_MODULE, 32'(m));
         ex(2, mod_g[m], mod_r[m]);
         ex(3, mod_g[m], mod_r[m]);
         check({31'h0, o_module_operational}, {31'h0, m != 4});
      end
      wr(`REG_MODULE, 32'h0);
      for (int n = 0; n < 5; n++) begin
         step(`REG_NETWORK, 32'(n));
         ex(0, net_g[n], net_r[n]);
         ex(1, net_g[n], net_r[n]);
      end
      step(`REG_CONFIG, 32'h2);
      ex(0, 32'h3E8, 32'h0);
      ex(2, 32'h3E8, 32'h0);
      check(both - both0, 32'h0);
      wr(`REG_CONFIG, 32'h0);
      repeat (10000) @(posedge i_clock);
      rd(`REG_STATE, v);
      check(v & 32'h1, 32'h0);
      wr(`REG_POWER_ON, 32'h1);
      rd(`REG_STATE, v);
      for (int t = 0; t < 1500 && v[0] !== 1'b1; t++)
         rd(`REG_STATE, v);
      if (v[0] !== 1'b1) begin
         num_errors++;
         tally_and_finish();
      end
      check(v & 32'h1, 32'h1);
      wr(`REG_POWER_ON, 32'hFF);
      // Normal mode from here on.
      step(`REG_NETWORK, 32'h2);
      ex(0, 32'h190, 32'h0);
      step(`REG_NETWORK, 32'h1);
      ex(0, 32'h7D0, 32'h0);
      ex(1, 32'h0, 32'h0);
      ex(2, 32'h0, 32'h0);
      ex(3, 32'h0, 32'h0);
      step(`REG_DRIVE, 32'h64);
      ex(1, 32'h7D0, 32'h0);
      step(`REG_DRIVE, 32'h32);
      ex(1, 32'h3E8, 32'h3E8);
      step(`REG_DRIVE, 32'h132);
      ex(1, 32'h3E8, 32'h0);
      step(`REG_DRIVE, 32'h332);
      ex(1, 32'h0, 32'h3E8);
      wr(`REG_DRIVE, 32'h0);
      step(`REG_SYSTEM, 32'h04);
      ex(2, 32'h7D0, 32'h0);
      step(`REG_SYSTEM, 32'h0C);
      ex(2, 32'h0, 32'h3E8);
      step(`REG_SYSTEM, 32'h0F);
      ex(2, 32'h0, 32'h7D0);
      step(`REG_SYSTEM, 32'h06);
      ex(2, 32'h7D0, 32'h7D0);
      step(`REG_SYSTEM, 32'h34);
      ex(2, 32'h7D0, 32'h7D0);
      ex(3, 32'h0, 32'h7D0);
      step(`REG_SYSTEM, 32'h64);
      ex(3, 32'h7D0, 32'h0);
      step(`REG_SYSTEM, 32'h44);
      ex(3, 32'h3E8, 32'h3E8);
      step(`REG_CONFIG, 32'h1);
      ex(2, 32'h7D0, 32'h0);
      ex(0, 32'h7D0, 32'h7D0);
      wr(`REG_CONFIG, 32'h0);
      wr(`REG_SYSTEM, 32'h04);
      snap();
      wr(`REG_BLINK, 32'h3);
      diff(5000);
      check(lamps - lamps0, 32'h3);
      ex(3, 32'h0, 32'h5DC);
      rd(`REG_BLINK, v);
      check(v, 32'h0);
      snap();
      diff(2000);
      check(lamps - lamps0, 32'h0);
      wr(`REG_INPUT_TYPE, 32'h01);
      wr(`REG_INPUT_LAMP, 32'h01);
      i_digital_input <= 8'h02;
      repeat (6) @(posedge i_clock);
      check({24'h0, o_input_lamp}, 32'h03);
      wr(`REG_INPUT_LAMP, 32'h00);
      repeat (4) @(posedge i_clock);
      check({24'h0, o_input_lamp}, 32'h02);
      wr(`REG_EXTRA, 32'hA5);
      repeat (2) @(posedge i_clock);
      check({24'h0, o_high_side_output, o_extra_indicator}, 32'hA5);
      rd(8'h2C, v);
      check(v, 32'h0);
      rd(`REG_STATE, v);
      check(v & 32'h1, 32'h1);
      tally_and_finish();
   end
endmodule

`default_nettype wire
